/* rtl/apo_pkg.sv */
package apo_pkg;

  // Output word and conversion pipeline geometry.
  localparam int          WORD_W      = 12;
  localparam int          STAGE_COUNT = 12;
  localparam int          LATENCY     = 7;
  localparam int          PAIR_REGS   = 5;
  localparam int          FIFO_DEPTH  = 4;

  // Residue arithmetic: one full-scale step equals 2048 output codes.
  localparam int          RES_W       = 14;
  localparam logic [13:0] FULL_SCALE  = 14'h0800;
  localparam logic [13:0] STAGE_THR   = 14'h0200;
  localparam int          TOP_WEIGHT  = 10;

  // Offset binary landmarks of the output code.
  localparam logic [11:0] CODE_ZERO   = 12'h800;
  localparam logic [11:0] CODE_MIN    = 12'h000;
  localparam logic [11:0] CODE_MAX    = 12'hfff;
  localparam logic [11:0] WORD_RESET  = 12'h000;

  // Sample clock limits that the clock source must respect, in kHz.
  localparam int          CLK_MIN_KHZ = 100;
  localparam int          CLK_MAX_KHZ = 60000;

  // Consecutive running cycles after which output words are fresh samples.
  localparam logic [3:0]  FRESH_RUN   = 4'h8;

endpackage : apo_pkg

/* rtl/apo_fifo.sv */
`timescale 1ns/10ps
module apo_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : apo_fifo

/* rtl/apo_adc_port.sv */
`timescale 1ns/10ps
module apo_adc_port
  import apo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  input  wire logic signed [11:0] analog_sample_i,
  input  wire logic               output_enable_n_i,
  input  wire logic               shutdown_request_i,
  output      logic [11:0]        sample_word_out_o,
  output      logic [5:0]         sample_word_low_bits_o,
  output      logic [5:0]         sample_word_high_bits_o,
  output      logic               sample_word_oe_o,
  output      logic               shutdown_active_o
);

  // One 1.5-bit decision step: residue doubles minus the decided reference,
  // and the decision adds its binary weight into the correction sum.
  function automatic logic [2*RES_W-1:0] apo_step(
    input logic signed [RES_W-1:0] res,
    input logic signed [RES_W-1:0] acc,
    input int                      idx
  );
    logic signed [RES_W-1:0] two_r;
    logic signed [RES_W-1:0] wt;
    two_r = res <<< 1;
    wt    = $signed(RES_W'(1) << (TOP_WEIGHT - idx));
    if (res > $signed(STAGE_THR)) begin
      apo_step = {two_r - $signed(FULL_SCALE), acc + wt};
    end else if (res < -$signed(STAGE_THR)) begin
      apo_step = {two_r + $signed(FULL_SCALE), acc - wt};
    end else begin
      apo_step = {two_r, acc};
    end
  endfunction : apo_step

  logic signed [RES_W-1:0] pr_res [PAIR_REGS+1];
  logic signed [RES_W-1:0] pr_acc [PAIR_REGS+1];
  logic                    pr_vld [PAIR_REGS+1];
  logic                    advance;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [WORD_W-1:0]       fifo_out_data;
  logic [WORD_W-1:0]       code_word;
  logic [2*RES_W-1:0]      last_pair;
  logic signed [RES_W-1:0] last_res;
  logic signed [RES_W-1:0] last_acc;
  logic signed [RES_W-1:0] code_full;
  logic [WORD_W-1:0]       out_word;
  logic                    out_load;

  // Conversion only moves while awake; a full buffer also holds the pipe
  // so no word is ever dropped between the stages and the output latch.
  assign advance = !shutdown_request_i && fifo_in_ready;

  // Track-and-hold: the input is caught on the rising clock edge.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pr_res[0] <= '0;
      pr_acc[0] <= '0;
      pr_vld[0] <= 1'b0;
    end else if (advance) begin
      pr_res[0] <= RES_W'(analog_sample_i);
      pr_acc[0] <= '0;
      pr_vld[0] <= 1'b1;
    end
  end

  // Each register holds the result of two stages, so a sample crosses one
  // stage per half clock period.
  for (genvar k = 1; k <= PAIR_REGS; k++) begin : g_pair
    logic [2*RES_W-1:0] first_s;
    logic [2*RES_W-1:0] second_s;
    assign first_s  = apo_step(pr_res[k-1], pr_acc[k-1], 2*k - 2);
    assign second_s = apo_step(first_s[2*RES_W-1:RES_W], first_s[RES_W-1:0], 2*k - 1);
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pr_res[k] <= '0;
        pr_acc[k] <= '0;
        pr_vld[k] <= 1'b0;
      end else if (advance) begin
        pr_res[k] <= second_s[2*RES_W-1:RES_W];
        pr_acc[k] <= second_s[RES_W-1:0];
        pr_vld[k] <= pr_vld[k-1];
      end
    end
  end

  // Stage eleven is a decision step; stage twelve only resolves the sign of
  // the remaining residue, which rounds the corrected sum down exactly.
  assign last_pair = apo_step(pr_res[PAIR_REGS], pr_acc[PAIR_REGS], STAGE_COUNT - 2);
  assign last_res  = last_pair[2*RES_W-1:RES_W];
  assign last_acc  = last_pair[RES_W-1:0];
  assign code_full = last_acc + $signed(RES_W'(CODE_ZERO))
                     - ((last_res < 0) ? $signed(RES_W'(1)) : $signed(RES_W'(0)));

  // Offset binary with saturation; the clamp never bites for legal input.
  always_comb begin
    if (code_full < 0) begin
      code_word = CODE_MIN;
    end else if (code_full > $signed(RES_W'(CODE_MAX))) begin
      code_word = CODE_MAX;
    end else begin
      code_word = code_full[WORD_W-1:0];
    end
  end

  apo_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (pr_vld[PAIR_REGS] && advance),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (code_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!shutdown_request_i),
    .out_data_o  (fifo_out_data)
  );

  // Output latch: the last pipeline step, frozen through shutdown.
  assign out_load = fifo_out_valid && !shutdown_request_i;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_word <= WORD_RESET;
    end else if (out_load) begin
      out_word <= fifo_out_data;
    end
  end

  assign sample_word_out_o       = out_word;
  assign sample_word_low_bits_o  = out_word[5:0];
  assign sample_word_high_bits_o = out_word[11:6];
  assign sample_word_oe_o        = !output_enable_n_i;
  assign shutdown_active_o       = shutdown_request_i;

  // Checking helpers: the ideal code of the present input and a count of
  // consecutive running cycles, after which words are fresh samples.
  logic [WORD_W-1:0] ideal_code;
  logic [3:0]        run_cnt;
  assign ideal_code = {~analog_sample_i[11], analog_sample_i[10:0]};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_cnt <= '0;
    end else if (shutdown_request_i) begin
      run_cnt <= '0;
    end else if (run_cnt != FRESH_RUN) begin
      run_cnt <= run_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_running_fresh;
    run_cnt == FRESH_RUN;
  endsequence

  // The sampled reset term keeps an attempt that starts on the releasing edge
  // from expecting a sample that the still-reset pipeline never took.
  sequence s_zero_in;
    arst_n_i && analog_sample_i == 12'sh000 && !shutdown_request_i;
  endsequence

  sequence s_neg_fs_in;
    arst_n_i && analog_sample_i == 12'sh800 && !shutdown_request_i;
  endsequence

  sequence s_awake_8;
    !shutdown_request_i [*8];
  endsequence

  a_oe_float: assert property (
    output_enable_n_i |-> !sample_word_oe_o)
    else $error("output lines driven while enable is high");

  a_oe_drive: assert property (
    !output_enable_n_i |-> sample_word_oe_o && sample_word_out_o == out_word)
    else $error("output lines not driven while enable is low");

  a_pipe_frozen: assert property (
    shutdown_request_i |=> $stable(pr_res[0]) && $stable(pr_acc[PAIR_REGS])
                           && $stable(pr_vld[PAIR_REGS]))
    else $error("pipeline moved during shutdown");

  a_bit_order: assert property (
    s_running_fresh |-> {sample_word_high_bits_o, sample_word_low_bits_o}
                        == $past(ideal_code, 8))
    else $error("word bits out of order");

  a_seven_latency: assert property (
    s_running_fresh |-> sample_word_out_o == $past(ideal_code, 8))
    else $error("word did not follow its sample by seven clocks");

  a_stage_step: assert property (
    arst_n_i && advance ##1 advance |=> pr_vld[PAIR_REGS] == $past(pr_vld[PAIR_REGS-1], 1)
                            && pr_vld[2] == $past(pr_vld[0], 2))
    else $error("sample did not advance two stages per clock");

  a_corrected_code: assert property (
    s_running_fresh |-> code_word == $past(ideal_code, 6))
    else $error("corrected stage sum does not match the sample");

  a_sample_edge: assert property (
    arst_n_i && advance |=> pr_res[0] == $past(analog_sample_i) && pr_vld[0])
    else $error("sample not taken on the rising edge");

  a_offset_zero: assert property (
    s_zero_in ##0 s_awake_8 |=> sample_word_out_o == CODE_ZERO)
    else $error("bipolar zero did not give the mid code");

  a_offset_min: assert property (
    s_neg_fs_in ##0 s_awake_8 |=> sample_word_out_o == CODE_MIN)
    else $error("negative full scale did not give all zeros");

  a_shutdown_hold: assert property (
    shutdown_request_i [*2] |-> $stable(sample_word_out_o))
    else $error("output word changed during shutdown");

endmodule : apo_adc_port

/* testbench/apo_capture_model.sv */
`timescale 1ns/10ps
module apo_capture_model
  import apo_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic [11:0] data_i,
  input  wire logic        oe_i,
  input  wire logic        shutdown_i,
  output      logic [11:0] bus_o,
  output      logic [11:0] word_o,
  output      logic        fresh_o
);
  logic [3:0] run_count;

  // The data lines have no pull, so a released bus shows the inverse of the last word.
  assign bus_o   = oe_i ? data_i : ~data_i;
  assign fresh_o = (run_count == FRESH_RUN);

  // Words that follow reset or shutdown are old pipeline contents and are not kept.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_count <= 4'h0;
    end else if (shutdown_i) begin
      run_count <= 4'h0;
    end else if (!fresh_o) begin
      run_count <= run_count + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_o <= 12'h000;
    end else if (fresh_o && oe_i) begin
      word_o <= bus_o;
    end
  end
endmodule : apo_capture_model

/* testbench/apo_adc_port_test.sv */
`timescale 1ns/10ps
module apo_adc_port_test;
  import apo_pkg::*;

  typedef struct {
    logic signed [11:0] sample;
    logic [11:0]        code;
  } apo_row_s;

  logic               clock_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic signed [11:0] analog_sample_i = 12'h000;
  logic               output_enable_n_i = 1'b0;
  logic               shutdown_request_i = 1'b0;
  logic [11:0]        sample_word_out_o;
  logic [5:0]         low_bits;
  logic [5:0]         high_bits;
  logic               word_oe;
  logic               sd_active;
  logic [11:0]        bus;
  logic [11:0]        captured;
  logic               fresh;
  int                 err_count = 0;
  int                 checks_done = 0;
  logic [11:0]        held;
  apo_row_s           rows [8] = '{
    '{12'sh000, 12'h800}, '{-12'sh001, 12'h7ff}, '{12'sh001, 12'h801},
    '{-12'sh800, 12'h000}, '{12'sh7ff, 12'hfff}, '{12'sh7fe, 12'hffe},
    '{-12'sh7ff, 12'h001}, '{12'sh155, 12'h955}};

  // 10 MHz sits inside the clock range the converter accepts.
  always #50 clock_i = ~clock_i;

  apo_adc_port i_apo_adc_port (
    .clock_i                 (clock_i),
    .arst_n_i                (arst_n_i),
    .analog_sample_i         (analog_sample_i),
    .output_enable_n_i       (output_enable_n_i),
    .shutdown_request_i      (shutdown_request_i),
    .sample_word_out_o       (sample_word_out_o),
    .sample_word_low_bits_o  (low_bits),
    .sample_word_high_bits_o (high_bits),
    .sample_word_oe_o        (word_oe),
    .shutdown_active_o       (sd_active)
  );

  apo_capture_model i_apo_capture_model (
    .clock_i    (clock_i),
    .arst_n_i   (arst_n_i),
    .data_i     (sample_word_out_o),
    .oe_i       (word_oe),
    .shutdown_i (sd_active),
    .bus_o      (bus),
    .word_o     (captured),
    .fresh_o    (fresh)
  );

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up;
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (12) @(posedge clock_i);
    #1 check(sample_word_out_o === WORD_RESET, "reset word");
    @(posedge clock_i) arst_n_i <= 1'b1;
    // A value driven at edge t is sampled at edge t+1 and shows after edge t+8.
    for (int t = 0; t < 16; t++) begin
      @(posedge clock_i);
      if (t < 8) analog_sample_i <= rows[t].sample;
      #1;
      if (t >= 8) begin
        check(sample_word_out_o === rows[t-8].code, "latency or code");
        check({high_bits, low_bits} === rows[t-8].code, "bit split");
        check(bus === rows[t-8].code && word_oe === 1'b1, "bus driven");
        check(t == 8 || captured === rows[t-9].code, "reader capture");
      end
    end
    @(posedge clock_i) output_enable_n_i <= 1'b1;
    #1 check(word_oe === 1'b0 && bus === ~sample_word_out_o, "bus not floated");
    @(posedge clock_i) output_enable_n_i <= 1'b0;
    shutdown_request_i <= 1'b1;
    analog_sample_i <= 12'sh123;
    #1 held = sample_word_out_o;
    check(sd_active === 1'b1, "shutdown flag");
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i) analog_sample_i <= 12'sh123 + 12'(i);
      #1 check(sample_word_out_o === held && bus === held, "word not held");
    end
    @(posedge clock_i) shutdown_request_i <= 1'b0;
    analog_sample_i <= -12'sh300;
    repeat (9) @(posedge clock_i);
    #1 check(sample_word_out_o === 12'h500, "resume after shutdown");
    check(fresh === 1'b1, "reader not fresh");
    @(posedge clock_i);
    #1 check(captured === 12'h500, "reader word");
    wrap_up();
  end

  initial begin
    #(200 * 100);
    err_count++;
    wrap_up();
  end
endmodule : apo_adc_port_test
